// [design/pll_ld_pkg.sv]
/*
 Constants, register map and carrier types for the PLL lock detect and
 holdover controller. Assumes a 100 MHz APB clock and 32-bit APB data.
*/
package pll_ld_pkg;

   // Register byte offsets
   localparam logic [7:0] off_r_div = 8'h00;
   localparam logic [7:0] off_n_div = 8'h04;
   localparam logic [7:0] off_delay_sync = 8'h08;
   localparam logic [7:0] off_lock_cfg = 8'h0c;
   localparam logic [7:0] off_pin_sel = 8'h10;
   localparam logic [7:0] off_holdover = 8'h14;
   localparam logic [7:0] off_state = 8'h18;
   localparam logic [7:0] off_irq_stat = 8'h1c;
   localparam logic [7:0] off_irq_mask = 8'h20;

   // Field positions
   localparam int r_div_w = 14;
   localparam int b_cnt_w = 13;
   localparam int a_cnt_w = 6;
   localparam int n_a_lsb = 16;
   localparam int n_psel_lsb = 24;
   localparam int n_dm_bit = 27;
   localparam int dly_fb_lsb = 3;
   localparam int sync_fld_lsb = 6;
   localparam int pin_status_lsb = 8;
   localparam int pin_reference_monitor_pin_lsb = 16;

   // Reset values
   localparam logic [31:0] r_div_rst = 32'h0000_0001;
   localparam logic [31:0] n_div_rst = 32'h0000_0003;
   localparam logic [7:0] delay_sync_rst = 8'h00;
   localparam logic [7:0] lock_cfg_rst = 8'h00;
   localparam logic [3:0] holdover_rst = 4'h0;

   // Pin mux selections
   localparam logic [5:0] sel_low = 6'h00;
   localparam logic [5:0] sel_dld = 6'h01;
   localparam logic [5:0] sel_cmp_high = 6'h02;
   localparam logic [5:0] sel_cmp_low = 6'h03;
   localparam logic [5:0] sel_lock_current = 6'h04;

   // Lock detect timing: thresholds and diff_max in pclk cycles, lock counts in detector cycles
   localparam logic [7:0] lock_thr_high_range = 8'h04;
   localparam logic [7:0] lock_thr_low_range = 8'h02;
   localparam logic [7:0] lock_count_0 = 8'h05;
   localparam logic [7:0] lock_count_1 = 8'h10;
   localparam logic [7:0] lock_count_2 = 8'h40;
   localparam logic [7:0] lock_count_3 = 8'hff;
   localparam logic [7:0] diff_max = 8'hff;

   // Interrupt bit positions
   localparam int irq_lock_gain = 0;
   localparam int irq_lock_loss = 1;
   localparam int irq_hold_entry = 2;
   localparam int irq_w = 3;

   typedef struct packed {
      logic [1:0] lock_count;
      logic window_low;
      logic dld_off;
      logic [1:0] spare;
      logic [1:0] abp;
   } lock_cfg_s;

   typedef struct packed {
      logic cmp_en;
      logic hold_en_b;
      logic manual;
      logic hold_en_a;
   } hold_cfg_s;

   typedef enum logic [1:0] {
      meas_idle,
      meas_wait_fb,
      meas_wait_ref
   } meas_state_e;

endpackage

// [design/bit_sync.sv]
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit changes slowly relative to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int width = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [design/pll_lock_detect_holdover.sv]
/*
 PLL reference and feedback dividers, digital lock detect, lock pin muxes
 and manual charge pump holdover, with an APB register slave.
 Assumes reference, feedback, align and comparator pins are asynchronous.
*/
// Our own choices: the APB interface to the registers and the register offsets.
// How it works
// - Enabled align reset clears R, A and B counters together while align is low
// - Align counter reset starts disabled after reset
// - Reference and feedback paths each get a three-bit selectable delay
// - Lock flag sets after programmed count of consecutive in-window detector cycles
// - Lock flag clears on one cycle beyond the unlock threshold
// - Unlock threshold is twice the lock threshold, giving hysteresis
// - Window bit, anti-backlash width and count setting shape lock timing
// - Lock flag selectable onto lock, status and monitor pins
// - Current-source mode sources current when locked, grounds pin otherwise
// - Comparator result selectable on monitor and status pins, either polarity
// - Holdover works only with both enable bits set
// - Align falling edge puts charge pump in high impedance in manual holdover
// - Charge pump leaves high impedance on next reference edge after align rises
// - B counter resets on the release event; prescaler keeps running
// - Feedback divides by prescaler times B plus A, prescaler 2 to 32
// - Reference divider is 14 bits; zero and one both divide by one
`timescale 1ns/1ps
`default_nettype none
module pll_lock_detect_holdover (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Detector inputs and pins
   input wire logic ref_clk_in,
   input wire logic fb_clk_in,
   input wire logic align_n,
   input wire logic lock_cmp_in,
   // Outputs
   output logic cp_hiz,
   output logic lock_pin_source,
   output logic lock_pin_ground,
   output logic lock_indicator_pin,
   output logic status_pin,
   output logic reference_monitor_pin,
   output logic irq
);
   logic [3:0] pins_sync;
   logic ref_prev_reg, fb_prev_reg, align_prev_reg;
   logic [31:0] r_div_reg, n_div_reg;
   logic [7:0] delay_sync_reg;
   pll_ld_pkg::lock_cfg_s lock_cfg_reg;
   pll_ld_pkg::hold_cfg_s hold_reg;
   logic [20:0] pin_sel_reg;
   logic [pll_ld_pkg::irq_w-1:0] irq_stat_reg, irq_mask_reg;
   logic [13:0] r_cnt_reg;
   logic [5:0] p_cnt_reg;
   logic [12:0] b_cnt_reg;
   logic [5:0] a_cnt_reg;
   logic [7:0] ref_dly_reg, fb_dly_reg;
   pll_ld_pkg::meas_state_e meas_reg;
   logic [7:0] diff_reg, good_reg;
   logic dld_reg;

   bit_sync #(.width(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({lock_cmp_in, align_n, fb_clk_in, ref_clk_in}),
      .sync_out(pins_sync)
   );

   wire ref_s = pins_sync[0];
   wire fb_s = pins_sync[1];
   wire align_s = pins_sync[2];
   wire ref_edge = ref_s & ~ref_prev_reg;
   wire fb_edge = fb_s & ~fb_prev_reg;
   wire align_fall = ~align_s & align_prev_reg;

   // APB decode
   wire wr_en = psel & penable & pwrite & pready;
   wire setup = psel & ~penable;
   wire hit = (paddr <= pll_ld_pkg::off_irq_mask) && (paddr[1:0] == 2'b00);
   wire wr_r = wr_en & hit & (paddr == pll_ld_pkg::off_r_div);
   wire wr_n = wr_en & hit & (paddr == pll_ld_pkg::off_n_div);
   wire wr_ds = wr_en & hit & (paddr == pll_ld_pkg::off_delay_sync);
   wire wr_lc = wr_en & hit & (paddr == pll_ld_pkg::off_lock_cfg);
   wire wr_ps = wr_en & hit & (paddr == pll_ld_pkg::off_pin_sel);
   wire wr_ho = wr_en & hit & (paddr == pll_ld_pkg::off_holdover);
   wire wr_is = wr_en & hit & (paddr == pll_ld_pkg::off_irq_stat);
   wire wr_im = wr_en & hit & (paddr == pll_ld_pkg::off_irq_mask);

   // divide by one for settings zero and one
   wire [13:0] r_set = r_div_reg[pll_ld_pkg::r_div_w-1:0];
   wire [13:0] r_last = (r_set <= 14'h0001) ? 14'h0000 : r_set - 14'h0001;

   // prescaler modulus and A, B counts
   wire [2:0] psel_f = n_div_reg[pll_ld_pkg::n_psel_lsb +: 3];
   wire [2:0] psel_c = (psel_f > 3'h4) ? 3'h4 : psel_f;
   wire [5:0] p_val = 6'h02 << psel_c;
   wire dm_mode = n_div_reg[pll_ld_pkg::n_dm_bit];
   wire [5:0] a_set = dm_mode ? n_div_reg[pll_ld_pkg::n_a_lsb +: pll_ld_pkg::a_cnt_w] : 6'h00;
   wire [12:0] b_set = n_div_reg[pll_ld_pkg::b_cnt_w-1:0];
   wire [12:0] b_last = (b_set == 13'h0000) ? 13'h0000 : b_set - 13'h0001;
   wire [5:0] p_mod = (a_cnt_reg < a_set) ? p_val + 6'h01 : p_val;
   wire p_out = fb_edge & (p_cnt_reg == p_mod - 6'h01);
   wire r_pulse = ref_edge & (r_cnt_reg == r_last);
   wire n_pulse = p_out & (b_cnt_reg == b_last);

   wire cnt_sync_rst = (delay_sync_reg[pll_ld_pkg::sync_fld_lsb +: 2] != 2'b00) & ~align_s;

   wire [2:0] ref_tap = delay_sync_reg[2:0];
   wire [2:0] fb_tap = delay_sync_reg[pll_ld_pkg::dly_fb_lsb +: 3];
   wire ref_pfd = ref_dly_reg[ref_tap];
   wire fb_pfd = fb_dly_reg[fb_tap];

   wire hold_en = hold_reg.hold_en_a & hold_reg.hold_en_b;
   wire hold_entry = hold_en & hold_reg.manual & align_fall;
   wire hold_release = cp_hiz & ~hold_entry & align_s & ref_pfd;

   // thresholds from window, anti-backlash and count
   wire [7:0] lock_thr = (lock_cfg_reg.window_low ? pll_ld_pkg::lock_thr_low_range
                          : pll_ld_pkg::lock_thr_high_range) + {6'h00, lock_cfg_reg.abp};
   wire [7:0] unlock_thr = {lock_thr[6:0], 1'b0};
   wire [7:0] lock_need = (lock_cfg_reg.lock_count == 2'b00) ? pll_ld_pkg::lock_count_0 :
                          (lock_cfg_reg.lock_count == 2'b01) ? pll_ld_pkg::lock_count_1 :
                          (lock_cfg_reg.lock_count == 2'b10) ? pll_ld_pkg::lock_count_2 :
                          pll_ld_pkg::lock_count_3;
   wire meas_done = ((meas_reg == pll_ld_pkg::meas_wait_fb) & fb_pfd)
                    | ((meas_reg == pll_ld_pkg::meas_wait_ref) & ref_pfd)
                    | ((meas_reg == pll_ld_pkg::meas_idle) & ref_pfd & fb_pfd);
   wire [7:0] diff_now = (meas_reg == pll_ld_pkg::meas_idle) ? 8'h00 : diff_reg;
   wire in_lock_win = diff_now < lock_thr;
   wire past_unlock = (diff_now > unlock_thr) | (diff_reg == pll_ld_pkg::diff_max);
   wire lock_set = ~dld_reg & meas_done & in_lock_win & (good_reg + 8'h01 >= lock_need);
   wire lock_clr = dld_reg & (lock_cfg_reg.dld_off | (meas_done & past_unlock)
                   | (diff_reg == pll_ld_pkg::diff_max));
   wire dld_next = lock_cfg_reg.dld_off ? 1'b0 : (lock_set | (dld_reg & ~lock_clr));

   // Pin muxes
   wire cmp_lvl = hold_reg.cmp_en ? pins_sync[3] : 1'b1;
   wire [5:0] ld_sel = pin_sel_reg[5:0];
   wire [5:0] st_sel = pin_sel_reg[pll_ld_pkg::pin_status_lsb +: 6];
   wire [5:0] rm_sel = {1'b0, pin_sel_reg[pll_ld_pkg::pin_reference_monitor_pin_lsb +: 5]};
   wire cur_mode = (ld_sel == pll_ld_pkg::sel_lock_current);
   wire st_next = (st_sel == pll_ld_pkg::sel_dld) ? dld_next :
                  (st_sel == pll_ld_pkg::sel_cmp_high) ? cmp_lvl :
                  (st_sel == pll_ld_pkg::sel_cmp_low) ? ~cmp_lvl : 1'b0;
   wire rm_next = (rm_sel == pll_ld_pkg::sel_dld) ? dld_next :
                  (rm_sel == pll_ld_pkg::sel_cmp_high) ? cmp_lvl :
                  (rm_sel == pll_ld_pkg::sel_cmp_low) ? ~cmp_lvl : 1'b0;

   // Interrupt events, set wins over clear
   wire [2:0] irq_evt = {hold_entry & ~cp_hiz, lock_clr, lock_set};
   wire [2:0] irq_stat_next = (irq_stat_reg & ~(wr_is ? pwdata[2:0] : 3'h0)) | irq_evt;

   // Read data
   wire [31:0] rd_mux = (paddr == pll_ld_pkg::off_r_div) ? r_div_reg :
                        (paddr == pll_ld_pkg::off_n_div) ? n_div_reg :
                        (paddr == pll_ld_pkg::off_delay_sync) ? {24'h0, delay_sync_reg} :
                        (paddr == pll_ld_pkg::off_lock_cfg) ? {25'h0, lock_cfg_reg[7:4], 1'b0, lock_cfg_reg[1:0]} :
                        (paddr == pll_ld_pkg::off_pin_sel) ? {11'h0, pin_sel_reg} :
                        (paddr == pll_ld_pkg::off_holdover) ? {28'h0, hold_reg} :
                        (paddr == pll_ld_pkg::off_state) ? {29'h0, cmp_lvl, cp_hiz, dld_reg} :
                        (paddr == pll_ld_pkg::off_irq_stat) ? {29'h0, irq_stat_reg} :
                        (paddr == pll_ld_pkg::off_irq_mask) ? {29'h0, irq_mask_reg} : 32'h0;

   // APB handshake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~hit;
         prdata <= (setup & ~pwrite & hit) ? rd_mux : 32'h0;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_div_reg <= pll_ld_pkg::r_div_rst;
         n_div_reg <= pll_ld_pkg::n_div_rst;
         delay_sync_reg <= pll_ld_pkg::delay_sync_rst;
         lock_cfg_reg <= pll_ld_pkg::lock_cfg_rst;
         pin_sel_reg <= 21'h0;
         hold_reg <= pll_ld_pkg::holdover_rst;
         irq_mask_reg <= 3'h0;
         irq_stat_reg <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_r)
            r_div_reg <= {18'h0, pwdata[13:0]};
         if (wr_n)
            n_div_reg <= {4'h0, pwdata[27:24], 2'h0, pwdata[21:16], 3'h0, pwdata[12:0]};
         if (wr_ds)
            delay_sync_reg <= pwdata[7:0];
         if (wr_lc)
            lock_cfg_reg <= {pwdata[6:3], 2'b00, pwdata[1:0]};
         if (wr_ps)
            pin_sel_reg <= {pwdata[20:16], 2'h0, pwdata[13:8], 2'h0, pwdata[5:0]};
         if (wr_ho)
            hold_reg <= pwdata[3:0];
         if (wr_im)
            irq_mask_reg <= pwdata[2:0];
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // Dividers and delay cells
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_prev_reg <= 1'b0;
         fb_prev_reg <= 1'b0;
         align_prev_reg <= 1'b0;
         r_cnt_reg <= 14'h0;
         p_cnt_reg <= 6'h0;
         b_cnt_reg <= 13'h0;
         a_cnt_reg <= 6'h0;
         ref_dly_reg <= 8'h0;
         fb_dly_reg <= 8'h0;
      end
      else
      begin
         ref_prev_reg <= ref_s;
         fb_prev_reg <= fb_s;
         align_prev_reg <= align_s;
         ref_dly_reg <= {ref_dly_reg[6:0], r_pulse};
         fb_dly_reg <= {fb_dly_reg[6:0], n_pulse};
         if (cnt_sync_rst)
            r_cnt_reg <= 14'h0;
         else if (ref_edge)
            r_cnt_reg <= r_pulse ? 14'h0 : r_cnt_reg + 14'h0001;
         if (fb_edge)
            p_cnt_reg <= p_out ? 6'h00 : p_cnt_reg + 6'h01;
         if (cnt_sync_rst | hold_release)
         begin
            b_cnt_reg <= 13'h0;
            a_cnt_reg <= 6'h0;
         end
         else if (p_out)
         begin
            b_cnt_reg <= n_pulse ? 13'h0000 : b_cnt_reg + 13'h0001;
            a_cnt_reg <= n_pulse ? 6'h00 : (a_cnt_reg < a_set) ? a_cnt_reg + 6'h01 : a_cnt_reg;
         end
      end
   end

   // Phase difference measurement and lock flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meas_reg <= pll_ld_pkg::meas_idle;
         diff_reg <= 8'h0;
         good_reg <= 8'h0;
         dld_reg <= 1'b0;
      end
      else
      begin
         case (meas_reg)
            pll_ld_pkg::meas_idle:
            begin
               diff_reg <= 8'h0;
               if (ref_pfd & ~fb_pfd)
                  meas_reg <= pll_ld_pkg::meas_wait_fb;
               else if (fb_pfd & ~ref_pfd)
                  meas_reg <= pll_ld_pkg::meas_wait_ref;
            end
            pll_ld_pkg::meas_wait_fb, pll_ld_pkg::meas_wait_ref:
            begin
               if (meas_done | (diff_reg == pll_ld_pkg::diff_max))
                  meas_reg <= pll_ld_pkg::meas_idle;
               diff_reg <= (diff_reg == pll_ld_pkg::diff_max) ? 8'h00 : diff_reg + 8'h01;
            end
            default:
               meas_reg <= pll_ld_pkg::meas_idle;
         endcase
         if (meas_done)
            good_reg <= (in_lock_win & (good_reg != 8'hff)) ? good_reg + 8'h01 : 8'h00;
         else if (diff_reg == pll_ld_pkg::diff_max)
            good_reg <= 8'h00;
         dld_reg <= dld_next;
      end
   end

   // Holdover and output pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cp_hiz <= 1'b0;
         lock_pin_source <= 1'b0;
         lock_pin_ground <= 1'b1;
         lock_indicator_pin <= 1'b0;
         status_pin <= 1'b0;
         reference_monitor_pin <= 1'b0;
      end
      else
      begin
         if (!hold_en)
            cp_hiz <= 1'b0;
         else if (hold_entry)
            cp_hiz <= 1'b1;
         else if (hold_release)
            cp_hiz <= 1'b0;
         lock_pin_source <= cur_mode & dld_next;
         lock_pin_ground <= cur_mode & ~dld_next;
         lock_indicator_pin <= (ld_sel == pll_ld_pkg::sel_dld) ? dld_next : 1'b0;
         status_pin <= st_next;
         reference_monitor_pin <= rm_next;
      end
   end
endmodule
`default_nettype wire

// [bench/ref_fb_src.sv]
/*
 Reference and feedback clock source for the lock detect bench.
 Feedback gives two rising edges per reference period, offset by skew ns.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_fb_src (
   // Control
   input wire logic run,
   input wire logic slip,
   input var int skew,
   // Clocks
   output logic ref_clk,
   output logic fb_clk
);
   initial ref_clk = 1'b0;
   initial fb_clk = 1'b0;

   // Reference stands low while stopped
   always
   begin
      wait (run);
      #3 ref_clk = 1'b1;
      #200 ref_clk = 1'b0;
      #197;
   end

   // Slip drops one feedback edge to shift the prescaler phase
   always @(posedge ref_clk)
   begin
      #(skew) fb_clk = 1'b1;
      #50 fb_clk = 1'b0;
      #150 fb_clk = !slip;
      #50 fb_clk = 1'b0;
   end
endmodule
`default_nettype wire

// [bench/pll_ld_asserts.sv]
/*
 Assertions for the lock detect and holdover block.
 Bound to the top module; shadows control registers from APB writes.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_ld_asserts (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic ref_clk_in,
   input wire logic fb_clk_in,
   input wire logic align_n,
   input wire logic lock_cmp_in,
   input wire logic cp_hiz,
   input wire logic lock_pin_source,
   input wire logic lock_pin_ground,
   input wire logic lock_indicator_pin,
   input wire logic status_pin,
   input wire logic reference_monitor_pin,
   input wire logic irq
);
   logic [3:0] hold_reg;
   logic [5:0] lsel_reg;
   logic [5:0] ssel_reg;
   logic [4:0] msel_reg;
   logic [2:0] mask_reg;
   logic [3:0] quiet_reg;
   wire logic wr = psel && penable && pready && pwrite && !pslverr;
   wire logic hold_ab = hold_reg[0] && hold_reg[2];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_reg <= 4'h0;
         {msel_reg, ssel_reg, lsel_reg, mask_reg} <= 20'h0;
      end
      else if (wr)
      begin
         if (paddr == pll_ld_pkg::off_holdover) hold_reg <= pwdata[3:0];
         if (paddr == pll_ld_pkg::off_pin_sel) {msel_reg, ssel_reg, lsel_reg} <= {pwdata[20:16], pwdata[13:8], pwdata[5:0]};
         if (paddr == pll_ld_pkg::off_irq_mask) mask_reg <= pwdata[2:0];
      end
   end

   // Cycles since the last reference rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) quiet_reg <= 4'h0;
      else if ($rose(ref_clk_in)) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_hold_fall;
      hold_ab && hold_reg[1] && $fell(align_n);
   endsequence
   sequence s_status_steady;
      ($stable(lock_cmp_in) && hold_reg[3] && ssel_reg == pll_ld_pkg::sel_cmp_high) [*5];
   endsequence
   sequence s_mon_steady;
      ($stable(lock_cmp_in) && hold_reg[3] && msel_reg == pll_ld_pkg::sel_cmp_low) [*5];
   endsequence

   property p_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
   property p_unmapped;
      s_setup ##0 paddr > 8'h20 |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_hiz_entry;
      s_hold_fall |-> ##[1:5] cp_hiz;
   endproperty
   a_hiz_entry: assert property (p_hiz_entry) else $error("no holdover after align fall");
   property p_hiz_gate;
      !hold_ab [*2] |-> !cp_hiz;
   endproperty
   a_hiz_gate: assert property (p_hiz_gate) else $error("holdover while disabled");
   property p_hiz_hold;
      cp_hiz && hold_ab && quiet_reg == 4'hf |=> cp_hiz;
   endproperty
   a_hiz_hold: assert property (p_hiz_hold) else $error("holdover left with no reference");
   property p_lock_pin;
      lock_indicator_pin |-> $past(lsel_reg) == pll_ld_pkg::sel_dld;
   endproperty
   a_lock_pin: assert property (p_lock_pin) else $error("lock pin high while not selected");
   property p_source;
      lock_pin_source |-> !lock_pin_ground && $past(lsel_reg) == pll_ld_pkg::sel_lock_current;
   endproperty
   a_source: assert property (p_source) else $error("current source outside its mode");
   property p_status_cmp;
      s_status_steady |-> status_pin == lock_cmp_in;
   endproperty
   a_status_cmp: assert property (p_status_cmp) else $error("status pin not comparator");
   property p_mon_cmp;
      s_mon_steady |-> reference_monitor_pin == !lock_cmp_in;
   endproperty
   a_mon_cmp: assert property (p_mon_cmp) else $error("monitor pin not inverted comparator");
   property p_irq;
      irq |-> $past(mask_reg) != 3'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with all events masked");
endmodule

bind pll_lock_detect_holdover pll_ld_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .ref_clk_in, .fb_clk_in, .align_n, .lock_cmp_in, .cp_hiz, .lock_pin_source,
   .lock_pin_ground, .lock_indicator_pin, .status_pin, .reference_monitor_pin, .irq);
`default_nettype wire

// [bench/pll_lock_detect_holdover_tb.sv]
/*
 Self-checking bench for the lock detect and holdover block.
 Assumes the clock source model drives the reference and feedback pins.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_lock_detect_holdover_tb;
   typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] wd; logic [31:0] rd;} row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic align_n = 1'b1, lock_cmp_in = 1'b0, run = 1'b0, slip = 1'b0;
   int skew = 0;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] q;
   logic e;
   row_s rows [6];
   wire logic [31:0] prdata;
   wire logic pready, pslverr, ref_clk_in, fb_clk_in, cp_hiz, lock_pin_source, lock_pin_ground;
   wire logic lock_indicator_pin, status_pin, reference_monitor_pin, irq;

   always #5 pclk = ~pclk;

   pll_lock_detect_holdover dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ref_clk_in, .fb_clk_in, .align_n, .lock_cmp_in, .cp_hiz, .lock_pin_source, .lock_pin_ground,
      .lock_indicator_pin, .status_pin, .reference_monitor_pin, .irq);
   ref_fb_src src (.run, .slip, .skew, .ref_clk(ref_clk_in), .fb_clk(fb_clk_in));

   task automatic close_out();
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1; n++) @(posedge pclk);
      chk(n, 0);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask

   function automatic logic pick(input int w);
      return (w == 0) ? lock_indicator_pin : (w == 1) ? lock_pin_ground : cp_hiz;
   endfunction

   task automatic wait_lvl(input int w, input logic v, input int lim);
      for (int n = 0; n < lim && pick(w) !== v; n++) @(posedge pclk);
      chk(pick(w), v);
   endtask

   // Second try slips the feedback phase by one edge
   task automatic get_lock();
      for (int t = 0; t < 2 && lock_indicator_pin !== 1'b1; t++)
      begin
         @(posedge ref_clk_in) slip = (t == 1);
         @(posedge ref_clk_in) slip = 1'b0;
         for (int n = 0; n < 600 && lock_indicator_pin !== 1'b1; n++) @(posedge pclk);
      end
      chk(lock_indicator_pin, 1'b1);
   endtask

   initial
   begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      close_out();
   end

   initial
   begin
      rows = '{'{pll_ld_pkg::off_r_div, 32'h0000_0001, 32'hffff_ffff, 32'h0000_3fff},
         '{pll_ld_pkg::off_n_div, 32'h0000_0003, 32'h0c3f_1fff, 32'h0c3f_1fff},
         '{pll_ld_pkg::off_delay_sync, 32'h0000_0000, 32'hffff_ffff, 32'h0000_00ff},
         '{pll_ld_pkg::off_lock_cfg, 32'h0000_0000, 32'hffff_ffff, 32'h0000_007b},
         '{pll_ld_pkg::off_holdover, 32'h0000_0000, 32'hffff_ffff, 32'h0000_000f},
         '{pll_ld_pkg::off_irq_mask, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0007}};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         rd(rows[i].a, rows[i].rst);
         wr(rows[i].a, rows[i].wd);
         rd(rows[i].a, rows[i].rd);
      end
      apb(1'b1, 8'h24, 32'h0000_0000);
      chk(e, 1'b1);
      apb(1'b0, 8'h02, 32'h0000_0000);
      chk(e, 1'b1);
      // Divide by one and two, equal taps, window high range
      wr(pll_ld_pkg::off_r_div, 32'h0000_0001);
      wr(pll_ld_pkg::off_n_div, 32'h0000_0001);
      wr(pll_ld_pkg::off_delay_sync, 32'h0000_001b);
      wr(pll_ld_pkg::off_lock_cfg, 32'h0000_0000);
      wr(pll_ld_pkg::off_irq_mask, 32'h0000_0007);
      wr(pll_ld_pkg::off_pin_sel, 32'h0003_0201);
      wr(pll_ld_pkg::off_holdover, 32'h0000_0008);
      run = 1'b1;
      for (int v = 0; v < 2; v++)
      begin
         lock_cmp_in <= v[0];
         repeat (6) @(posedge pclk);
         chk(status_pin, v[0]);
         chk(reference_monitor_pin, !v[0]);
      end
      get_lock();
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      skew = 60;
      repeat (400) @(posedge pclk);
      chk(lock_indicator_pin, 1'b1);
      skew = 120;
      wait_lvl(0, 1'b0, 200);
      skew = 0;
      get_lock();
      wr(pll_ld_pkg::off_pin_sel, 32'h0003_0204);
      repeat (3) @(posedge pclk);
      chk({lock_pin_source, lock_pin_ground}, 2'b10);
      skew = 120;
      wait_lvl(1, 1'b1, 300);
      chk(lock_pin_source, 1'b0);
      skew = 0;
      wr(pll_ld_pkg::off_pin_sel, 32'h0003_0201);
      get_lock();
      wr(pll_ld_pkg::off_delay_sync, 32'h0000_005b);
      align_n <= 1'b0;
      repeat (400) @(posedge pclk);
      chk(lock_indicator_pin, 1'b1);
      align_n <= 1'b1;
      wr(pll_ld_pkg::off_delay_sync, 32'h0000_001b);
      get_lock();
      rd(pll_ld_pkg::off_irq_stat, 32'h0000_0003);
      wr(pll_ld_pkg::off_irq_mask, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      wr(pll_ld_pkg::off_irq_stat, 32'h0000_0007);
      rd(pll_ld_pkg::off_irq_stat, 32'h0000_0000);
      wr(pll_ld_pkg::off_irq_mask, 32'h0000_0007);
      // Manual holdover; channel dividers outside here ignore align
      wr(pll_ld_pkg::off_holdover, 32'h0000_000b);
      align_n <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(cp_hiz, 1'b0);
      wr(pll_ld_pkg::off_holdover, 32'h0000_000f);
      repeat (10) @(posedge pclk);
      chk(cp_hiz, 1'b0);
      align_n <= 1'b1;
      repeat (10) @(posedge pclk);
      align_n <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(cp_hiz, 1'b1);
      rd(pll_ld_pkg::off_irq_stat, 32'h0000_0004);
      run = 1'b0;
      repeat (100) @(posedge pclk);
      align_n <= 1'b1;
      repeat (60) @(posedge pclk);
      chk(cp_hiz, 1'b1);
      run = 1'b1;
      wait_lvl(2, 1'b0, 100);
      get_lock();
      // Enables cleared before a calibration
      wr(pll_ld_pkg::off_holdover, 32'h0000_0000);
      close_out();
   end
endmodule
`default_nettype wire
